// ### pkg/bridge_window_pkg.sv
// shared constants and types of the bridge memory window registers
package bridge_window_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int WIDE_W = 64;
	localparam int HALF_W = 32;
	localparam int FIELD_W = 12;
	localparam int IND_W = 4;
	localparam int LOW_W = 20;
	localparam int REG16_W = 16;

	localparam logic [ADDR_W-1:0] OFF_MEM_BASE = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_MEM_LIMIT = 8'h22;
	localparam logic [ADDR_W-1:0] OFF_PF_BASE = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_PF_LIMIT = 8'h26;
	localparam logic [ADDR_W-1:0] OFF_PF_BASE_UP = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_PF_LIMIT_UP = 8'h2c;

	localparam logic [IND_W-1:0] RSVD_IND = 4'h0;
	localparam logic [IND_W-1:0] WIDE_IND = 4'h1;
	localparam logic [FIELD_W-1:0] FIELD_RESET = 12'h000;
	localparam logic [HALF_W-1:0] UPPER_RESET = 32'h00000000;
	localparam logic [HALF_W-1:0] UPPER_NONE = 32'h00000000;
	localparam logic [LOW_W-1:0] LOW_ZERO = 20'h00000;
	localparam logic [LOW_W-1:0] LOW_ONES = 20'hfffff;
	localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h00000000;
	localparam logic [REG16_W-1:0] PAD16 = 16'h0000;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [WIDE_W-1:0] bottom;
		logic [WIDE_W-1:0] top;
	} window_bounds_t;

endpackage : bridge_window_pkg

// ### rtl/window_field_reg.sv
// 16-bit window register: writable address field over a fixed low nibble
`timescale 1ns/1ps
`default_nettype none
module window_field_reg
	import bridge_window_pkg::*;
#(
	parameter logic [ADDR_W-1:0] OFFSET = OFF_MEM_BASE,
	parameter logic [IND_W-1:0] LOW_NIBBLE = RSVD_IND
)
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire reg_req_t req_i,
	output logic [FIELD_W-1:0] field_o,
	output logic [REG16_W-1:0] value_o
);

	logic [FIELD_W-1:0] field;

	// write takes bits 15:4, low nibble ignores writes
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			field <= FIELD_RESET;
		else if (req_i.wr && req_i.addr == OFFSET)
			field <= req_i.wdata[REG16_W-1:IND_W];
	end

	assign field_o = field;
	assign value_o = {field, LOW_NIBBLE};

endmodule : window_field_reg
`default_nettype wire

// ### rtl/window_range_check.sv
// inclusive base/limit compare of one address against one window
`timescale 1ns/1ps
`default_nettype none
module window_range_check
	import bridge_window_pkg::*;
#(
	parameter int W = WIDE_W
)
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [W-1:0] addr_i,
	input wire logic [W-1:0] bottom_i,
	input wire logic [W-1:0] top_i,
	output logic hit_o
);

	logic next_hit;

	assign next_hit = (addr_i >= bottom_i) && (addr_i <= top_i);

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			hit_o <= 1'b0;
		else
			hit_o <= next_hit;
	end

	a_hit_inclusive:
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!sys_rst_i |=> hit_o == ($past(addr_i) >= $past(bottom_i) && $past(addr_i) <= $past(top_i)))
	else $error("window hit does not match inclusive compare");

endmodule : window_range_check
`default_nettype wire

// ### rtl/bridge_memory_window_regs.sv
// bridge memory window registers with window hit detection
// Function
// - memory limit sets non-prefetchable window top
// - limit bits 15:4 are address 31:20, low ones
// - limit low nibble ignores writes, reads zero
// - prefetch base bits 15:4 are bottom 31:20
// - prefetch base low nibble reads 1h
// - prefetch limit bits 15:4 are top 31:20
// - prefetch limit low nibble reads 1h
// - upper base gives bottom bits 63:32
// - upper limit gives top bits 63:32
// - upper base fully writable 32 bits
// - memory base bits 15:4 are bottom 31:20
`timescale 1ns/1ps
`default_nettype none
module bridge_memory_window_regs
	import bridge_window_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic [WIDE_W-1:0] query_addr_i,
	output logic mem_hit_o,
	output logic prefetch_hit_o,
	output var window_bounds_t mem_window_o,
	output var window_bounds_t prefetch_window_o
);

	reg_req_t req;
	logic [FIELD_W-1:0] window_bottom_field;
	logic [FIELD_W-1:0] mem_top_field;
	logic [FIELD_W-1:0] prefetch_bottom_field;
	logic [FIELD_W-1:0] prefetch_top_field;
	logic [REG16_W-1:0] mem_base_value;
	logic [REG16_W-1:0] mem_limit_value;
	logic [REG16_W-1:0] prefetch_base_value;
	logic [REG16_W-1:0] prefetch_limit_value;
	logic [HALF_W-1:0] prefetch_base_upper;
	logic [HALF_W-1:0] prefetch_limit_upper;
	logic [DATA_W-1:0] next_rdata;
	logic addr_mapped;
	window_bounds_t mem_bounds;
	window_bounds_t prefetch_bounds;

	// bundle the register port
	assign req.addr = reg_addr_i;
	assign req.wdata = reg_wdata_i;
	assign req.wr = reg_wr_i;
	assign req.rd = reg_rd_i;

	// non-prefetchable window bottom, low nibble reserved
	window_field_reg #(
		.OFFSET(OFF_MEM_BASE),
		.LOW_NIBBLE(RSVD_IND)
	) u_mem_base (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.req_i(req),
		.field_o(window_bottom_field),
		.value_o(mem_base_value)
	);

	// non-prefetchable window top, low nibble reserved
	window_field_reg #(
		.OFFSET(OFF_MEM_LIMIT),
		.LOW_NIBBLE(RSVD_IND)
	) u_mem_limit (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.req_i(req),
		.field_o(mem_top_field),
		.value_o(mem_limit_value)
	);

	// prefetchable window bottom, wide addressing indicator
	window_field_reg #(
		.OFFSET(OFF_PF_BASE),
		.LOW_NIBBLE(WIDE_IND)
	) u_pf_base (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.req_i(req),
		.field_o(prefetch_bottom_field),
		.value_o(prefetch_base_value)
	);

	// prefetchable window top, wide addressing indicator
	window_field_reg #(
		.OFFSET(OFF_PF_LIMIT),
		.LOW_NIBBLE(WIDE_IND)
	) u_pf_limit (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.req_i(req),
		.field_o(prefetch_top_field),
		.value_o(prefetch_limit_value)
	);

	// upper half of prefetchable bottom
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			prefetch_base_upper <= UPPER_RESET;
		else if (req.wr && req.addr == OFF_PF_BASE_UP)
			prefetch_base_upper <= req.wdata;
	end

	// upper half of prefetchable top
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			prefetch_limit_upper <= UPPER_RESET;
		else if (req.wr && req.addr == OFF_PF_LIMIT_UP)
			prefetch_limit_upper <= req.wdata;
	end

	// expand fields to full window addresses
	assign mem_bounds.bottom = {UPPER_NONE, window_bottom_field, LOW_ZERO};
	assign mem_bounds.top = {UPPER_NONE, mem_top_field, LOW_ONES};
	assign prefetch_bounds.bottom = {prefetch_base_upper, prefetch_bottom_field, LOW_ZERO};
	assign prefetch_bounds.top = {prefetch_limit_upper, prefetch_top_field, LOW_ONES};

	// registered copies of the windows
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			mem_window_o <= '0;
			prefetch_window_o <= '0;
		end
		else
		begin
			mem_window_o <= mem_bounds;
			prefetch_window_o <= prefetch_bounds;
		end
	end

	// forwarding decision for each window
	window_range_check #(
		.W(WIDE_W)
	) u_mem_check (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.addr_i(query_addr_i),
		.bottom_i(mem_bounds.bottom),
		.top_i(mem_bounds.top),
		.hit_o(mem_hit_o)
	);

	window_range_check #(
		.W(WIDE_W)
	) u_pf_check (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.addr_i(query_addr_i),
		.bottom_i(prefetch_bounds.bottom),
		.top_i(prefetch_bounds.top),
		.hit_o(prefetch_hit_o)
	);

	// read mux, unmapped offsets read zero
	always_comb
	begin
		next_rdata = RDATA_IDLE;
		addr_mapped = 1'b1;
		case (req.addr)
			OFF_MEM_BASE: next_rdata = {PAD16, mem_base_value};
			OFF_MEM_LIMIT: next_rdata = {PAD16, mem_limit_value};
			OFF_PF_BASE: next_rdata = {PAD16, prefetch_base_value};
			OFF_PF_LIMIT: next_rdata = {PAD16, prefetch_limit_value};
			OFF_PF_BASE_UP: next_rdata = prefetch_base_upper;
			OFF_PF_LIMIT_UP: next_rdata = prefetch_limit_upper;
			default:
			begin
				next_rdata = RDATA_IDLE;
				addr_mapped = 1'b0;
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			reg_rdata_o <= RDATA_IDLE;
			reg_rvalid_o <= 1'b0;
		end
		else
		begin
			reg_rdata_o <= req.rd ? next_rdata : RDATA_IDLE;
			reg_rvalid_o <= req.rd;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking

	default disable iff (sys_rst_i);

	a_limit_low_zero:
	assert property (req.rd && req.addr == OFF_MEM_LIMIT |=> reg_rdata_o[IND_W-1:0] == RSVD_IND)
	else $error("memory limit low nibble not zero");

	a_limit_write_field:
	assert property (req.wr && req.addr == OFF_MEM_LIMIT
		|=> mem_top_field == $past(reg_wdata_i[REG16_W-1:IND_W]))
	else $error("memory limit field not taken from bits 15:4");

	a_mem_top_ones:
	assert property (mem_bounds.top[LOW_W-1:0] == LOW_ONES
		&& mem_bounds.top[HALF_W-1:LOW_W] == mem_top_field
		&& mem_bounds.top[WIDE_W-1:HALF_W] == UPPER_NONE)
	else $error("memory window top badly expanded");

	a_mem_base_read:
	assert property (req.rd && req.addr == OFF_MEM_BASE
		|=> reg_rdata_o == {PAD16, $past(window_bottom_field), RSVD_IND})
	else $error("memory base read value wrong");

	a_pf_base_ind:
	assert property (req.rd && req.addr == OFF_PF_BASE |=> reg_rdata_o[IND_W-1:0] == WIDE_IND)
	else $error("prefetch base indicator not 1h");

	a_pf_limit_ind:
	assert property (req.rd && req.addr == OFF_PF_LIMIT |=> reg_rdata_o[IND_W-1:0] == WIDE_IND)
	else $error("prefetch limit indicator not 1h");

	a_pf_bottom_expand:
	assert property (prefetch_bounds.bottom[LOW_W-1:0] == LOW_ZERO
		&& prefetch_bounds.bottom[HALF_W-1:LOW_W] == prefetch_bottom_field)
	else $error("prefetch bottom low bits wrong");

	a_pf_top_expand:
	assert property (req.wr && req.addr == OFF_PF_LIMIT
		|=> prefetch_bounds.top[HALF_W-1:LOW_W] == $past(reg_wdata_i[REG16_W-1:IND_W])
		&& prefetch_bounds.top[LOW_W-1:0] == LOW_ONES)
	else $error("prefetch top not updated from write");

	a_pf_bottom_upper:
	assert property (req.wr && req.addr == OFF_PF_BASE_UP
		|=> prefetch_bounds.bottom[WIDE_W-1:HALF_W] == $past(reg_wdata_i))
	else $error("prefetch bottom upper half not written");

	a_pf_top_upper:
	assert property (req.wr && req.addr == OFF_PF_LIMIT_UP
		|=> prefetch_bounds.top[WIDE_W-1:HALF_W] == $past(reg_wdata_i))
	else $error("prefetch top upper half not written");

	a_upper_readback:
	assert property (req.wr && req.addr == OFF_PF_BASE_UP ##1 req.rd && req.addr == OFF_PF_BASE_UP
		|=> reg_rdata_o == $past(reg_wdata_i, 2))
	else $error("upper base does not read back written word");

	a_upper_hold:
	assert property (!(req.wr && req.addr == OFF_PF_BASE_UP)
		|=> prefetch_base_upper == $past(prefetch_base_upper))
	else $error("upper base changed without a write");

	a_reset_clear:
	assert property (@(posedge clk_i) disable iff (1'b0)
		sys_rst_i |=> window_bottom_field == FIELD_RESET && mem_top_field == FIELD_RESET
		&& prefetch_bottom_field == FIELD_RESET && prefetch_top_field == FIELD_RESET
		&& prefetch_base_upper == UPPER_RESET && prefetch_limit_upper == UPPER_RESET
		&& prefetch_base_value[IND_W-1:0] == WIDE_IND)
	else $error("reset values wrong");

	a_rdata_only_once:
	assert property (!req.rd |=> reg_rdata_o == RDATA_IDLE && !reg_rvalid_o)
	else $error("read data outside the answer cycle");

	a_unmapped_zero:
	assert property (req.rd && !addr_mapped |=> reg_rdata_o == RDATA_IDLE && reg_rvalid_o)
	else $error("unmapped read not zero");

	a_window_out_lag:
	assert property (!sys_rst_i |=> prefetch_window_o == $past(prefetch_bounds)
		&& mem_window_o == $past(mem_bounds))
	else $error("window outputs do not follow bounds");

	a_rvalid_after_read:
	assert property (req.rd |=> reg_rvalid_o)
	else $error("read valid missing after read strobe");

	a_mem_bottom_expand:
	assert property (mem_bounds.bottom[LOW_W-1:0] == LOW_ZERO
		&& mem_bounds.bottom[HALF_W-1:LOW_W] == window_bottom_field
		&& mem_bounds.bottom[WIDE_W-1:HALF_W] == UPPER_NONE)
	else $error("memory window bottom badly expanded");

	a_mem_base_write:
	assert property (req.wr && req.addr == OFF_MEM_BASE
		|=> window_bottom_field == $past(reg_wdata_i[REG16_W-1:IND_W]))
	else $error("memory base field not taken from bits 15:4");

	a_limit_field_hold:
	assert property (!(req.wr && req.addr == OFF_MEM_LIMIT) |=> $stable(mem_top_field))
	else $error("memory limit changed without a write");

	a_limit_read_value:
	assert property (req.rd && req.addr == OFF_MEM_LIMIT
		|=> reg_rdata_o == {PAD16, $past(mem_top_field), RSVD_IND})
	else $error("memory limit read value wrong");

	a_pf_base_write:
	assert property (req.wr && req.addr == OFF_PF_BASE
		|=> prefetch_bottom_field == $past(reg_wdata_i[REG16_W-1:IND_W]))
	else $error("prefetch base field not taken from bits 15:4");

	a_pf_base_read:
	assert property (req.rd && req.addr == OFF_PF_BASE
		|=> reg_rdata_o == {PAD16, $past(prefetch_bottom_field), WIDE_IND})
	else $error("prefetch base read value wrong");

	a_pf_limit_read:
	assert property (req.rd && req.addr == OFF_PF_LIMIT
		|=> reg_rdata_o == {PAD16, $past(prefetch_top_field), WIDE_IND})
	else $error("prefetch limit read value wrong");

	a_upper_base_read:
	assert property (req.rd && req.addr == OFF_PF_BASE_UP |=> reg_rdata_o == $past(prefetch_base_upper))
	else $error("upper base read value wrong");

	a_upper_limit_read:
	assert property (req.rd && req.addr == OFF_PF_LIMIT_UP |=> reg_rdata_o == $past(prefetch_limit_upper))
	else $error("upper limit read value wrong");

	a_upper_limit_hold:
	assert property (!(req.wr && req.addr == OFF_PF_LIMIT_UP)
		|=> prefetch_limit_upper == $past(prefetch_limit_upper))
	else $error("upper limit changed without a write");

	a_reset_outputs:
	assert property (@(posedge clk_i) disable iff (1'b0)
		sys_rst_i |=> reg_rdata_o == RDATA_IDLE && !reg_rvalid_o && !mem_hit_o && !prefetch_hit_o)
	else $error("outputs not idle after reset");

endmodule : bridge_memory_window_regs
`default_nettype wire

// ### tb/host_sw_model.sv
// host software model driving the register port
`timescale 1ns/1ps
`default_nettype none
module host_sw_model
	import bridge_window_pkg::*;
(
	input wire logic clk_i,
	input wire logic [DATA_W-1:0] rdata_i,
	output logic [ADDR_W-1:0] addr_o,
	output logic [DATA_W-1:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	initial
	begin
		addr_o <= 8'h00;
		wdata_o <= 32'h00000000;
		wr_o <= 1'b0;
		rd_o <= 1'b0;
	end
	// called right after a rising edge; strobe stays up for back-to-back writes
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
	endtask : wr_reg
	// ends a run of writes
	task automatic idle;
		wr_o <= 1'b0;
		@(posedge clk_i);
	endtask : idle
	// read data taken at the edge closing the answer cycle
	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		wr_o <= 1'b0;
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(posedge clk_i);
		d = rdata_i;
	endtask : rd_reg
	// upper base cleared when only 32-bit addressing is used
	task automatic use_32bit;
		wr_reg(OFF_PF_BASE_UP, UPPER_NONE);
	endtask : use_32bit
endmodule : host_sw_model
`default_nettype wire

// ### tb/bridge_memory_window_regs_tb.sv
// testbench of the bridge memory window registers
`timescale 1ns/1ps
`default_nettype none
module bridge_memory_window_regs_tb
	import bridge_window_pkg::*;
;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [DATA_W-1:0] reg_rdata;
	logic reg_rvalid;
	logic [WIDE_W-1:0] query_addr = 64'h0;
	logic mem_hit;
	logic pf_hit;
	window_bounds_t mem_win;
	window_bounds_t pf_win;
	int fail_count = 0;
	int check_count = 0;

	always #5 clk_i = ~clk_i;

	bridge_memory_window_regs bridge_memory_window_regs_inst (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
		.query_addr_i(query_addr), .mem_hit_o(mem_hit), .prefetch_hit_o(pf_hit),
		.mem_window_o(mem_win), .prefetch_window_o(pf_win)
	);
	host_sw_model host_sw_model_inst (
		.clk_i(clk_i), .rdata_i(reg_rdata), .addr_o(reg_addr), .wdata_o(reg_wdata),
		.wr_o(reg_wr), .rd_o(reg_rd)
	);

	task automatic chk(input logic [127:0] seen, input logic [127:0] exp, input string msg);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] d;
		host_sw_model_inst.rd_reg(a, d);
		chk(128'(d), 128'(exp), "read data");
		chk(128'(reg_rvalid), 128'h1, "read valid");
	endtask : rd_chk
	task automatic q_chk(input logic [WIDE_W-1:0] a, input logic em, input logic ep);
		query_addr <= a;
		@(posedge clk_i);
		@(posedge clk_i);
		chk(128'({mem_hit, pf_hit}), 128'({em, ep}), "window hits");
	endtask : q_chk
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	task automatic t_reset;
		rd_chk(OFF_MEM_BASE, 32'h00000000);
		rd_chk(OFF_MEM_LIMIT, 32'h00000000);
		rd_chk(OFF_PF_BASE, 32'h00000001);
		rd_chk(OFF_PF_LIMIT, 32'h00000001);
		rd_chk(OFF_PF_BASE_UP, 32'h00000000);
		rd_chk(OFF_PF_LIMIT_UP, 32'h00000000);
		chk(mem_win, {64'h0, 64'h00000000000fffff}, "mem window");
		chk(pf_win, {64'h0, 64'h00000000000fffff}, "prefetch window");
		$display("reset test done");
	endtask : t_reset
	task automatic t_mem;
		host_sw_model_inst.wr_reg(OFF_MEM_BASE, 32'hffff1235);
		host_sw_model_inst.wr_reg(OFF_MEM_LIMIT, 32'h0000abcf);
		rd_chk(OFF_MEM_BASE, 32'h00001230);
		rd_chk(OFF_MEM_LIMIT, 32'h0000abc0);
		chk(mem_win, {64'h12300000, 64'habcfffff}, "mem window");
		q_chk(64'h12300000, 1'b1, 1'b0);
		q_chk(64'h122fffff, 1'b0, 1'b0);
		q_chk(64'habcfffff, 1'b1, 1'b0);
		q_chk(64'habd00000, 1'b0, 1'b0);
		q_chk(64'h1_12300000, 1'b0, 1'b0);
		$display("memory window test done");
	endtask : t_mem
	task automatic t_prefetch;
		host_sw_model_inst.wr_reg(OFF_PF_BASE, 32'h0000001e);
		host_sw_model_inst.wr_reg(OFF_PF_LIMIT, 32'h0000002e);
		host_sw_model_inst.wr_reg(OFF_PF_BASE_UP, 32'h00000001);
		host_sw_model_inst.wr_reg(OFF_PF_LIMIT_UP, 32'h00000002);
		rd_chk(OFF_PF_BASE, 32'h00000011);
		rd_chk(OFF_PF_LIMIT, 32'h00000021);
		rd_chk(OFF_PF_BASE_UP, 32'h00000001);
		rd_chk(OFF_PF_LIMIT_UP, 32'h00000002);
		chk(pf_win, {64'h1_00100000, 64'h2_002fffff}, "prefetch window");
		q_chk(64'h1_00100000, 1'b0, 1'b1);
		q_chk(64'h1_000fffff, 1'b0, 1'b0);
		q_chk(64'h2_002fffff, 1'b0, 1'b1);
		q_chk(64'h2_00300000, 1'b0, 1'b0);
		host_sw_model_inst.use_32bit();
		host_sw_model_inst.wr_reg(OFF_PF_BASE_UP, 32'hfedcba98);
		rd_chk(OFF_PF_BASE_UP, 32'hfedcba98);
		host_sw_model_inst.use_32bit();
		host_sw_model_inst.idle();
		q_chk(64'h00100000, 1'b0, 1'b1);
		$display("prefetch window test done");
	endtask : t_prefetch
	task automatic t_unmapped;
		host_sw_model_inst.wr_reg(8'h40, 32'hffffffff);
		rd_chk(8'h40, 32'h00000000);
		rd_chk(OFF_MEM_LIMIT, 32'h0000abc0);
		$display("unmapped test done");
	endtask : t_unmapped
	task automatic t_rerun_reset;
		sys_rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd_chk(OFF_MEM_LIMIT, 32'h00000000);
		rd_chk(OFF_PF_LIMIT, 32'h00000001);
		rd_chk(OFF_PF_LIMIT_UP, 32'h00000000);
		chk(pf_win, {64'h0, 64'h00000000000fffff}, "prefetch window");
		q_chk(64'h000fffff, 1'b1, 1'b1);
		$display("second reset test done");
	endtask : t_rerun_reset

	initial
	begin
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_mem();
		t_prefetch();
		t_unmapped();
		t_rerun_reset();
		end_of_test();
	end
	initial
	begin
		#100us;
		fail_count++;
		end_of_test();
	end
endmodule : bridge_memory_window_regs_tb
`default_nettype wire
